// ==== design/hsb_host_map.vh ====
// register map, device addresses and timing constants of the host controller
`ifndef HSB_HOST_MAP_VH
`define HSB_HOST_MAP_VH
// controller registers on the wishbone bus (word index = adr[4:2])
`define HSB_REG_CTRL       3'h0
`define HSB_REG_WDATA      3'h1
`define HSB_REG_RDATA      3'h2
`define HSB_REG_STATUS     3'h3
`define HSB_REG_STRAP      3'h4
// ctrl fields
`define HSB_CTRL_ADDR_HI   7
`define HSB_CTRL_ADDR_LO   0
// status fields
`define HSB_ST_BUSY        0
`define HSB_ST_DONE        1
`define HSB_ST_REFUSED     2
`define HSB_ST_IRQ         3
`define HSB_ST_STRAP_LO    4
// reset values
`define HSB_STRAP_RST      2'h3
// device addresses
`define HSB_DEV_RESET      8'h01
`define HSB_DEV_AUX_CFG    8'ha7
`define HSB_DEV_CSUM_A_LO  8'ha9
`define HSB_DEV_CSUM_A_HI  8'haa
`define HSB_DEV_GAIN       8'hb1
`define HSB_DEV_TX0        8'hb5
`define HSB_DEV_TX1        8'hb6
`define HSB_DEV_TX2        8'hb7
`define HSB_DEV_CSUM_B_LO  8'hb8
`define HSB_DEV_CSUM_B_HI  8'hb9
`define HSB_DEV_PWR_DOWN   8'hc0
`define HSB_DEV_MODE       8'hc1
`define HSB_DEV_TX5        8'hc2
`define HSB_DEV_IDENT      8'hc5
`define HSB_DEV_STATUS     8'hc6
`define HSB_DEV_TX6        8'hc7
`define HSB_DEV_PROG       8'hc8
`define HSB_DEV_VERSION    8'hc9
`define HSB_DEV_TX3        8'hca
`define HSB_DEV_TX4        8'hcb
`define HSB_DEV_AUX_CFG2   8'hcd
`define HSB_DEV_MASK       8'hce
// timing
`define HSB_CLK_MHZ        50
`define HSB_SCLK_HALF_NS   100
`define HSB_SCLK_HALF_CYC  ((`HSB_SCLK_HALF_NS * `HSB_CLK_MHZ) / 1000)
`define HSB_WR_SETTLE_US   250
`define HSB_WR_SETTLE_CYC  (`HSB_WR_SETTLE_US * `HSB_CLK_MHZ)
`endif

// ==== design/hsb_host_ctrl.v ====
// host-side controller driving the serial control port of the modulator
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
`include "hsb_host_map.vh"

// Overview of operation
// - each transaction is one address byte then zero or more data bytes.
// - host holds select low through a transaction, high between them.
// - the address value fixes data byte count and direction.
// - address and data bytes travel most significant bit first.
// - a register write may need 250 us before it takes effect.
// - a command is one 8-bit address with no data; one code resets.
// - command and reply lines are never active together.
// - clock may idle high or low; gaps between bytes are allowed.
// - straps sampled only at power-on or general reset; keep stable.
// - after load, ident, version, checksums shown; then 32-bit activation.
// - straps both low before general reset to restart without reload.
// - host writes first transmit block before selecting transmit mode.
// - refill event asks for new transmit data before the buffer runs dry.
module hsb_host_ctrl #(
  parameter SCLK_HALF_CYC = `HSB_SCLK_HALF_CYC,
  parameter WR_SETTLE_CYC = `HSB_WR_SETTLE_CYC
) (
  // clock and reset
  input  wire        ref_clk_in,
  input  wire        rst_n_in,
  // wishbone slave
  input  wire        wb_cyc_in,
  input  wire        wb_stb_in,
  input  wire        wb_we_in,
  input  wire [2:0]  wb_adr_in,
  input  wire [3:0]  wb_sel_in,
  input  wire [31:0] wb_dat_in,
  output reg  [31:0] wb_dat_out,
  output reg         wb_ack_out,
  // serial port to the device
  output reg         port_select_n_out,
  output reg         serial_clk_out,
  output reg         cmd_data_out,
  input  wire        reply_data_in,
  input  wire        host_interrupt_n_in,
  // boot straps
  output reg         boot_strap_a_out,
  output reg         boot_strap_b_out
);

  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_SETUP  = 3'h1;
  localparam [2:0] ST_LOW    = 3'h2;
  localparam [2:0] ST_HIGH   = 3'h3;
  localparam [2:0] ST_END    = 3'h4;
  localparam [2:0] ST_SETTLE = 3'h5;

  // counter end points cut to the counter width on purpose
  localparam integer HALF_LAST_I   = SCLK_HALF_CYC - 1;
  localparam integer SETTLE_LAST_I = WR_SETTLE_CYC - 1;
  localparam [15:0]  HALF_LAST     = HALF_LAST_I[15:0];
  localparam [15:0]  SETTLE_LAST   = SETTLE_LAST_I[15:0];
  localparam [1:0]   STRAP_RST     = `HSB_STRAP_RST;

  // {valid, read, has two data bytes} per device address
  function [2:0] addr_kind;
    input [7:0] a;
    begin
      case (a)
        `HSB_DEV_RESET:     addr_kind = 3'h4;
        `HSB_DEV_CSUM_A_LO, `HSB_DEV_CSUM_A_HI,
        `HSB_DEV_CSUM_B_LO, `HSB_DEV_CSUM_B_HI,
        `HSB_DEV_IDENT,     `HSB_DEV_STATUS,
        `HSB_DEV_VERSION:   addr_kind = 3'h7;
        `HSB_DEV_AUX_CFG,   `HSB_DEV_GAIN,
        `HSB_DEV_TX0,       `HSB_DEV_TX1,
        `HSB_DEV_TX2,       `HSB_DEV_TX3,
        `HSB_DEV_TX4,       `HSB_DEV_TX5,
        `HSB_DEV_TX6,       `HSB_DEV_PWR_DOWN,
        `HSB_DEV_MODE,      `HSB_DEV_PROG,
        `HSB_DEV_AUX_CFG2,  `HSB_DEV_MASK:
                            addr_kind = 3'h5;
        default:            addr_kind = 3'h0;
      endcase
    end
  endfunction

  reg  [2:0]  state;
  reg  [15:0] cnt;
  reg  [4:0]  bits_left;
  reg  [23:0] tx_shift;
  reg  [15:0] rx_shift;
  reg  [15:0] wdata;
  reg  [15:0] rdata;
  reg         is_read;
  reg         is_wdata;
  reg         done;
  reg         refused;
  reg         rep_s1;
  reg         rep_s2;
  reg         irq_s1;
  reg         irq_s2;

  wire        wb_req  = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  // writes land at the edge where the master sees ack high
  wire        wb_wr   = wb_cyc_in & wb_stb_in & wb_ack_out & wb_we_in;
  wire        ctrl_wr = wb_wr & (wb_adr_in == `HSB_REG_CTRL) & wb_sel_in[0];
  wire [7:0]  new_adr = wb_dat_in[`HSB_CTRL_ADDR_HI:`HSB_CTRL_ADDR_LO];
  wire [2:0]  kind    = addr_kind(new_adr);
  wire        idle    = (state == ST_IDLE);
  wire        go      = ctrl_wr & idle & kind[2];
  wire        refuse  = ctrl_wr & ~go;
  wire        half_up = (cnt == HALF_LAST);
  wire        st_wr   = wb_wr & (wb_adr_in == `HSB_REG_STATUS) &
                        wb_sel_in[0];

  // pins from outside pass two flip-flops
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rep_s1 <= 1'b0;
      rep_s2 <= 1'b0;
      irq_s1 <= 1'b1;
      irq_s2 <= 1'b1;
    end else begin
      rep_s1 <= reply_data_in;
      rep_s2 <= rep_s1;
      irq_s1 <= host_interrupt_n_in;
      irq_s2 <= irq_s1;
    end
  end

  // serial transaction engine
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state             <= ST_IDLE;
      cnt               <= 16'h0000;
      bits_left         <= 5'h00;
      tx_shift          <= 24'h00_0000;
      rx_shift          <= 16'h0000;
      rdata             <= 16'h0000;
      is_read           <= 1'b0;
      is_wdata          <= 1'b0;
      port_select_n_out <= 1'b1;
      serial_clk_out    <= 1'b0;
      cmd_data_out      <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          cnt <= 16'h0000;
          if (go) begin
            // length and direction follow from the address
            is_read   <= kind[1];
            is_wdata  <= kind[0] & ~kind[1];
            bits_left <= kind[0] ? 5'd24 : 5'd8;
            // read data phase shifts out zeros: command line stays quiet
            tx_shift  <= {new_adr, kind[1] ? 16'h0000 : wdata};
            port_select_n_out <= 1'b0;
            state     <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          cnt <= half_up ? 16'h0000 : cnt + 16'h0001;
          if (half_up) begin
            cmd_data_out <= tx_shift[23];
            state        <= ST_LOW;
          end
        end
        ST_LOW: begin
          cnt <= half_up ? 16'h0000 : cnt + 16'h0001;
          if (half_up) begin
            serial_clk_out <= 1'b1;
            state          <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          cnt <= half_up ? 16'h0000 : cnt + 16'h0001;
          if (half_up) begin
            serial_clk_out <= 1'b0;
            // reply is sampled late in the high phase
            if (is_read && bits_left <= 5'd16)
              rx_shift <= {rx_shift[14:0], rep_s2};
            tx_shift     <= {tx_shift[22:0], 1'b0};
            cmd_data_out <= tx_shift[22];
            bits_left    <= bits_left - 5'd1;
            state        <= (bits_left == 5'd1) ? ST_END : ST_LOW;
          end
        end
        ST_END: begin
          cmd_data_out <= 1'b0;
          cnt <= half_up ? 16'h0000 : cnt + 16'h0001;
          if (half_up) begin
            port_select_n_out <= 1'b1;
            if (is_read)
              rdata <= rx_shift;
            state <= is_wdata ? ST_SETTLE : ST_IDLE;
          end
        end
        ST_SETTLE: begin
          // hold off the next transaction until the write has landed
          cnt <= cnt + 16'h0001;
          if (cnt == SETTLE_LAST) begin
            cnt   <= 16'h0000;
            state <= ST_IDLE;
          end
        end
        default: begin
          state             <= ST_IDLE;
          port_select_n_out <= 1'b1;
          serial_clk_out    <= 1'b0;
          cmd_data_out      <= 1'b0;
        end
      endcase
    end
  end

  wire finish = (state == ST_END) & half_up & ~is_wdata |
                (state == ST_SETTLE) & (cnt == SETTLE_LAST);

  // software registers; hardware set wins over a clear
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      wdata            <= 16'h0000;
      done             <= 1'b0;
      refused          <= 1'b0;
      boot_strap_a_out <= STRAP_RST[0];
      boot_strap_b_out <= STRAP_RST[1];
    end else begin
      if (wb_wr && wb_adr_in == `HSB_REG_WDATA) begin
        if (wb_sel_in[0])
          wdata[7:0] <= wb_dat_in[7:0];
        if (wb_sel_in[1])
          wdata[15:8] <= wb_dat_in[15:8];
      end
      // straps are set before a reset command and held through loading
      if (wb_wr && wb_adr_in == `HSB_REG_STRAP && wb_sel_in[0]) begin
        boot_strap_a_out <= wb_dat_in[0];
        boot_strap_b_out <= wb_dat_in[1];
      end
      if (finish)
        done <= 1'b1;
      else if (st_wr && wb_dat_in[`HSB_ST_DONE])
        done <= 1'b0;
      if (refuse)
        refused <= 1'b1;
      else if (st_wr && wb_dat_in[`HSB_ST_REFUSED])
        refused <= 1'b0;
    end
  end

  // wishbone answer one cycle after the strobe
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= wb_req;
      wb_dat_out <= 32'h0000_0000;
      if (wb_req && !wb_we_in) begin
        case (wb_adr_in)
          `HSB_REG_WDATA:  wb_dat_out <= {16'h0000, wdata};
          `HSB_REG_RDATA:  wb_dat_out <= {16'h0000, rdata};
          `HSB_REG_STATUS: wb_dat_out <= {26'h00_0000,
                                          boot_strap_b_out,
                                          boot_strap_a_out,
                                          ~irq_s2,
                                          refused, done, ~idle};
          `HSB_REG_STRAP:  wb_dat_out <= {30'h000_0000,
                                          boot_strap_b_out,
                                          boot_strap_a_out};
          default:         wb_dat_out <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// ==== tb/hsb_host_props.sv ====
// assertions on the ports of the host serial port controller
`timescale 1ns/1ps
module hsb_host_props #(
  parameter SCLK_HALF_CYC = 5
) (
  // clock and reset
  input wire        ref_clk_in,
  input wire        rst_n_in,
  // wishbone
  input wire        wb_cyc_in,
  input wire        wb_stb_in,
  input wire        wb_we_in,
  input wire [2:0]  wb_adr_in,
  input wire [31:0] wb_dat_out,
  input wire        wb_ack_out,
  // serial port
  input wire        port_select_n_out,
  input wire        serial_clk_out,
  input wire        cmd_data_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  reg [7:0] hi_cnt;
  always @(posedge ref_clk_in) begin
    hi_cnt <= serial_clk_out ? hi_cnt + 8'h01 : 8'h00;
  end
  a_ack_one_cycle: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held too long");
  a_ack_after_req: assert property
    (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack missing");
  a_ack_no_req: assert property (!(wb_cyc_in && wb_stb_in) |=> !wb_ack_out)
    else $error("ack without request");
  a_dat_idle_zero: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
    else $error("read data outside ack");
  a_unmapped_zero: assert property
    (wb_ack_out && !wb_we_in && wb_adr_in > 3'h4 |-> wb_dat_out == 32'h0)
    else $error("unmapped read not zero");
  a_busy_in_frame: assert property (wb_ack_out && !wb_we_in &&
    wb_adr_in == 3'h3 && !port_select_n_out |-> wb_dat_out[0])
    else $error("busy low in frame");
  a_sclk_idle_low: assert property
    (port_select_n_out |-> !serial_clk_out)
    else $error("clock moves outside frame");
  a_cmd_idle_low: assert property
    (port_select_n_out |-> !cmd_data_out)
    else $error("command active outside frame");
  a_cmd_held_high: assert property
    (serial_clk_out |-> $stable(cmd_data_out))
    else $error("command changes while clock high");
  a_sclk_half_high: assert property
    ($fell(serial_clk_out) |-> int'(hi_cnt) == SCLK_HALF_CYC)
    else $error("clock high phase length");
  a_frame_lead: assert property
    ($fell(port_select_n_out) |-> !serial_clk_out [*8])
    else $error("clock too soon after select");
  cover property ($fell(port_select_n_out));
  cover property ($rose(serial_clk_out));
  cover property (wb_ack_out && wb_adr_in == 3'h2);
endmodule
bind hsb_host_ctrl hsb_host_props #(.SCLK_HALF_CYC(SCLK_HALF_CYC))
  u_props (.*);

// ==== tb/hsb_dev_model.sv ====
// behavioural device on the far side of the serial control port
`timescale 1ns/1ps
module hsb_dev_model (
  // serial port
  input  wire       sel_n_in,
  input  wire       sclk_in,
  input  wire       cmd_in,
  output reg        reply_out,
  output wire       irq_n_out,
  // boot straps
  input  wire [1:0] strap_in
);
  reg  [23:0] sr;
  reg  [4:0]  cnt = 0;
  reg  [7:0]  addr = 0;
  reg  [15:0] status = 0, mask = 0, rdat = 0;
  reg  [1:0]  strap = 2'h3;
  reg         tx_mode = 0, tx_ready = 0, order_bad = 0, deaf = 0;
  reg  [1:0]  act_n = 0;
  reg  [31:0] act = 0;
  // activation code the model accepts; the value is arbitrary
  localparam [31:0] ACT_CODE = 32'h5a5a_c3c3;
  wire rd = addr inside {8'ha9, 8'haa, 8'hb8, 8'hb9, 8'hc5, 8'hc6, 8'hc9};
  wire irq = mask[15] && |(status[14:0] & mask[14:0]);
  assign irq_n_out = irq ? 1'b0 : 1'bz;
  initial reply_out = 0;
  always @(negedge sel_n_in) cnt = 0;
  always @(posedge sclk_in) if (!sel_n_in) begin
    sr = {sr[22:0], cmd_in};
    cnt = cnt + 5'd1;
    if (cnt == 5'd8) begin
      addr = sr[7:0];
      // ident, version and checksums show an arbitrary address pattern
      rdat = (addr == 8'hc6) ? {irq, status[14:0]} : {addr, ~addr};
      if (deaf && addr == 8'ha9) rdat = 16'hdead;
      if (addr == 8'hc6) status[14:1] = 0;
      // a general reset reloads per straps: 01 would read its own image
      if (addr == 8'h01 && !deaf) begin
        strap = strap_in;
        tx_mode = 1'b0;
        act_n = 2'd0;
      end
    end
    // a deaf model drops every write and command
    if (cnt == 5'd24 && !rd && !deaf) begin
      if (addr == 8'hce) mask = sr[15:0];
      if (addr == 8'hb5) begin
        status[1] = 1'b1;
        tx_ready = 1'b1;
      end
      if (addr == 8'hc1) begin
        if (sr[0] && !tx_ready) order_bad = 1'b1;
        tx_mode = sr[0];
      end
      // programming port only listens in idle mode
      if (addr == 8'hc8 && !tx_mode && act_n != 2'd2) begin
        act = {act[15:0], sr[15:0]};
        act_n = act_n + 2'd1;
        if (act_n == 2'd2 && act != ACT_CODE) deaf = 1'b1;
      end
    end
  end
  always @(negedge sclk_in)
    if (!sel_n_in && rd && cnt >= 5'd8 && cnt < 5'd24)
      reply_out = rdat[5'd23 - cnt];
    else reply_out = ~reply_out;
endmodule

// ==== tb/host_serial_boot_irq_port_test.sv ====
// self-checking bench for the host serial port controller
`timescale 1ns/1ps
`include "hsb_host_map.vh"
module host_serial_boot_irq_port_test;
  reg         clk = 0, rst_n = 0, cyc = 0, we = 0;
  reg  [2:0]  adr = 0;
  reg  [31:0] wdat = 0, rd;
  reg  [15:0] d;
  reg  [31:0] eq[$], mq[$];
  reg  [7:0]  ra [0:5] = '{8'ha9, 8'haa, 8'hb8, 8'hb9, 8'hc5, 8'hc9};
  wire [31:0] dat;
  wire        ack, sel_n, sclk, cmd, reply, sa, sb;
  tri1        irq_n;
  integer     bad_count = 0, num_checks = 0, i;
  always #10 clk = ~clk;
  hsb_host_ctrl #(.WR_SETTLE_CYC(20)) dut (
    .ref_clk_in(clk), .rst_n_in(rst_n), .wb_cyc_in(cyc), .wb_stb_in(cyc),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'h3), .wb_dat_in(wdat),
    .wb_dat_out(dat), .wb_ack_out(ack), .port_select_n_out(sel_n),
    .serial_clk_out(sclk), .cmd_data_out(cmd), .reply_data_in(reply),
    .host_interrupt_n_in(irq_n), .boot_strap_a_out(sa),
    .boot_strap_b_out(sb));
  hsb_dev_model dev (.sel_n_in(sel_n), .sclk_in(sclk), .cmd_in(cmd),
    .reply_out(reply), .irq_n_out(irq_n), .strap_in({sb, sa}));
  task chk(input string n, input [31:0] e, s, m);
    begin
      num_checks = num_checks + 1;
      if ((s & m) !== (e & m)) begin
        bad_count = bad_count + 1;
        $display("Error %s expected %h seen %h", n, e & m, s & m);
      end
    end
  endtask
  task wb(input w, input [2:0] a, input [31:0] v, e, m);
    begin
      @(posedge clk);
      cyc <= 1;
      we <= w;
      adr <= a;
      wdat <= v;
      if (!w) begin
        eq.push_back(e);
        mq.push_back(m);
      end
      // only the watchdog ends a wait for ack
      do begin
        @(posedge clk);
      end while (ack !== 1'b1);
      rd = dat;
      cyc <= 0;
    end
  endtask
  task xfer(input [7:0] a, input [15:0] v);
    begin
      wb(1, `HSB_REG_WDATA, v, 0, 0);
      wb(1, `HSB_REG_CTRL, a, 0, 0);
      rd = 1;
      while (rd[0] !== 1'b0)
        wb(0, `HSB_REG_STATUS, 0, 0, 0);
    end
  endtask
  // read results are matched against the oldest note
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && mq.size() > 0) begin
      if (mq[0] != 0) chk("wb_dat_out", eq[0], dat, mq[0]);
      void'(eq.pop_front());
      void'(mq.pop_front());
    end
  end
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    #(40000 * 20);
    bad_count = bad_count + 1;
    print_verdict;
  end
  initial begin
    i = $urandom(32'h3046_d926);
    repeat (8) @(posedge clk);
    rst_n <= 1;
    wb(0, `HSB_REG_STATUS, 0, 32'h30, 32'h3f);
    wb(0, 3'h6, 0, 0, 32'hffff_ffff);
    $display("test reset done");
    for (i = 0; i < 6; i = i + 1) begin
      xfer(ra[i], 16'($urandom));
      wb(0, `HSB_REG_RDATA, 0, {ra[i], ~ra[i]}, 32'hffff);
    end
    $display("test reads done");
    xfer(`HSB_DEV_TX0, 16'($urandom));
    wb(0, `HSB_REG_STATUS, 0, 0, 32'h8);
    xfer(`HSB_DEV_MODE, 16'h0001);
    chk("order", 0, dev.order_bad, 32'h1);
    d = 16'($urandom) | 16'h8002;
    xfer(`HSB_DEV_MASK, d);
    chk("mask", d, dev.mask, 32'hffff);
    wb(0, `HSB_REG_STATUS, 0, 32'h8, 32'h8);
    xfer(`HSB_DEV_STATUS, 0);
    wb(0, `HSB_REG_RDATA, 0, 32'h8002, 32'hffff);
    wb(0, `HSB_REG_STATUS, 0, 0, 32'h8);
    wb(1, `HSB_REG_CTRL, 32'h55, 0, 0);
    wb(0, `HSB_REG_STATUS, 0, 32'h6, 32'h7);
    wb(1, `HSB_REG_STATUS, 32'h6, 0, 0);
    wb(0, `HSB_REG_STATUS, 0, 0, 32'h7);
    $display("test events done");
    wb(1, `HSB_REG_STRAP, 0, 0, 0);
    xfer(`HSB_DEV_RESET, 0);
    chk("strap", 0, dev.strap, 32'h3);
    wb(0, `HSB_REG_STATUS, 0, 0, 32'h30);
    $display("test reset command done");
    xfer(`HSB_DEV_PROG, 16'($urandom));
    xfer(`HSB_DEV_PROG, 16'h0000);
    xfer(`HSB_DEV_CSUM_A_LO, 0);
    wb(0, `HSB_REG_RDATA, 0, 32'hdead, 32'hffff);
    wb(1, `HSB_REG_STRAP, 3, 0, 0);
    xfer(`HSB_DEV_RESET, 0);
    chk("deaf strap", 0, dev.strap, 32'h3);
    $display("test activation done");
    print_verdict;
  end
endmodule
